// File: etdm_ahb_regs.sv
// ahb-lite register slave of the transmit descriptor manager
// assumes single word transfers; zero wait states, always okay
`timescale 1ns/10ps
`default_nettype none
`include "etdm_consts.svh"
module etdm_ahb_regs (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  etdm_regs_if.slv         r
);
  logic        wr_pend_reg;
  logic [7:0]  wa_reg;
  logic [31:0] hrdata_reg;
  logic        txen_reg, pause_reg, start_reg, halt_reg, qpw_reg;
  logic [31:0] qp_reg;

  ////////////////////////////////////////////////////////////////////
  wire       sel_ok = hsel & hready & htrans[1];
  wire [7:0] ra     = haddr[7:0];
  wire wr_ncr = wr_pend_reg && (wa_reg == `ETDM_OFS_NCR);
  wire wr_cfg = wr_pend_reg && (wa_reg == `ETDM_OFS_CFG);
  wire wr_tqp = wr_pend_reg && (wa_reg == `ETDM_OFS_TQP);
  wire [31:0] tsr_word = (32'(r.err_bits) << `ETDM_D_EXH) |
                         (32'(r.go) << `ETDM_TSR_GO); // see R15
  // unmapped addresses read zero
  wire [31:0] rd_word =
    (ra == `ETDM_OFS_NCR) ? (32'(txen_reg) << `ETDM_NCR_TXEN) :
    (ra == `ETDM_OFS_CFG) ? (32'(pause_reg) << `ETDM_CFG_PAUSE) :
    (ra == `ETDM_OFS_TSR) ? tsr_word :
    (ra == `ETDM_OFS_TQP) ? r.cur_ptr : `ETDM_RST_WORD;

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend_reg <= 1'b0;
      wa_reg      <= 8'h00;
      hrdata_reg  <= `ETDM_RST_WORD;
    end else begin
      wr_pend_reg <= sel_ok & hwrite;
      wa_reg      <= ra;
      if (sel_ok & ~hwrite) begin
        hrdata_reg <= rd_word;
      end
    end
  end

  // start, halt and pointer writes become one-cycle pulses
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txen_reg  <= 1'b0;
      pause_reg <= 1'b0;
      start_reg <= 1'b0;
      halt_reg  <= 1'b0;
      qpw_reg   <= 1'b0;
      qp_reg    <= `ETDM_RST_WORD;
    end else begin
      start_reg <= wr_ncr & hwdata[`ETDM_NCR_START];
      halt_reg  <= wr_ncr & hwdata[`ETDM_NCR_HALT];
      qpw_reg   <= wr_tqp;
      if (wr_ncr) txen_reg <= hwdata[`ETDM_NCR_TXEN];
      if (wr_cfg) pause_reg <= hwdata[`ETDM_CFG_PAUSE];
      if (wr_tqp) qp_reg <= hwdata;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign r.tx_en    = txen_reg;
  assign r.pause_en = pause_reg;
  assign r.start_p  = start_reg;
  assign r.halt_p   = halt_reg;
  assign r.qp_wr_p  = qpw_reg;
  assign r.qp_base  = qp_reg;
endmodule // etdm_ahb_regs
`default_nettype wire

// File: etdm_consts.svh
// constants of the transmit descriptor manager: offsets, bits, counts
// assumes one include per compile unit; guarded anyway
`ifndef ETDM_CONSTS_SVH
`define ETDM_CONSTS_SVH
// register byte offsets (haddr[7:0])
`define ETDM_OFS_NCR     8'h00
`define ETDM_OFS_CFG     8'h04
`define ETDM_OFS_TSR     8'h08
`define ETDM_OFS_TQP     8'h0C
// control, config and status bits
`define ETDM_NCR_TXEN    3
`define ETDM_NCR_START   9
`define ETDM_NCR_HALT    10
`define ETDM_CFG_PAUSE   13
`define ETDM_TSR_GO      3
// descriptor word 1 fields
`define ETDM_D_USED      31
`define ETDM_D_WRAP      30
`define ETDM_D_RLE       29
`define ETDM_D_UND       28
`define ETDM_D_EXH       27
`define ETDM_D_NOCRC     16
`define ETDM_D_LAST      15
`define ETDM_D_LEN_MSB   10
`define ETDM_CTRL_OFS    32'h0000_0004
// reset values
`define ETDM_RST_WORD    32'h0000_0000
// ring and frame sizes
`define ETDM_RING_LAST   10'h3FF
`define ETDM_MIN_FRAME   18'h00040
`define ETDM_CRC_BYTES   18'h00004
`define ETDM_WORD_BYTES  11'h004
`endif

// File: etdm_mem_model.sv
// memory behind the descriptor engine: word array, ack after lat cycles
// assumes the engine's clk and word aligned addresses below 0x400
`timescale 1ns/10ps
`default_nettype none
module etdm_mem_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  lat,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic             mem_err,
  output logic      [31:0] mem_rdata
);
  logic [31:0] mem [0:255];
  logic [3:0]  wait_reg;
  //////////////////////////////////////////////////////////////////////
  assign mem_err = 1'b0;
  // rdata flips outside ack so a late sample never looks valid
  always @(posedge clk) begin
    if (sys_rst) begin
      mem_ack   <= 1'b0;
      wait_reg  <= 4'h0;
      mem_rdata <= 32'h0000_0000;
    end else if (mem_req && !mem_ack && wait_reg == lat) begin
      mem_ack   <= 1'b1;
      wait_reg  <= 4'h0;
      mem_rdata <= mem[mem_addr[9:2]];
      if (mem_we) begin
        mem[mem_addr[9:2]] <= mem_wdata;
      end
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_reg  <= (mem_req && !mem_ack) ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule // etdm_mem_model
`default_nettype wire

// File: etdm_pkg.sv
// types and shared helpers of the transmit descriptor manager
// assumes nothing beyond a SystemVerilog compiler
package etdm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_CTRL = 3'h2,
    ST_DATA = 3'h3,
    ST_PAD  = 3'h4,
    ST_WAIT = 3'h5,
    ST_WB   = 3'h6
  } etdm_state_t;

  // two words per descriptor
  function automatic logic [31:0] desc_addr(input logic [31:0] base,
                                            input logic [9:0]  idx);
    return base + {19'h00000, idx, 3'h0};
  endfunction
endpackage

// File: etdm_regs_if.sv
// carrier between the bus slave and the descriptor engine
// assumes both ends run on the same clk
`timescale 1ns/10ps
`default_nettype none
interface etdm_regs_if;
  logic        tx_en;
  logic        pause_en;
  logic        start_p;
  logic        halt_p;
  logic        qp_wr_p;
  logic [31:0] qp_base;
  logic        go;
  logic [2:0]  err_bits;
  logic [31:0] cur_ptr;
  modport slv  (output tx_en, pause_en, start_p, halt_p, qp_wr_p, qp_base,
                input go, err_bits, cur_ptr);
  modport core (input tx_en, pause_en, start_p, halt_p, qp_wr_p, qp_base,
                output go, err_bits, cur_ptr);
endinterface
`default_nettype wire

// File: etdm_tx_desc.sv
// transmit descriptor manager: ring walker, buffer fetch, status write
// assumes word aligned buffers, a same-clock memory port and mac core
// Summary of operation
// R1: buffers of 0 to 2047 bytes accepted
// R2: software uses at most 128 buffers a frame
// R3: descriptor is address word plus control word
// R4: crc frames padded to 64 bytes minimum
// R5: length 10:0, last 15, no crc 16
// R6: send only unowned; set used on first buffer (the code sets it only when no error bits are written back)
// R7: software clears used before buffer reuse
// R8: status bits written to first control word
// R9: underrun on bus error, late data, exhaustion
// R10: wrap bit or 1024 entries returns to start
// R11: software leaves pointer alone while active
// R12: pointer write restarts ring, clears go
// R13: transmit disable returns pointer to start
// R14: start sets go; rewrite while active harmless
// R15: go readable at status bit 3
// R16: go cleared by disable, owned, write, halt, errors
// R17: halt waits for current frame end
// R18: collision restarts from frame's first buffer
// R19: owned mid-frame: error output, bad fcs
// R20: after error pointer returns to ring start
// R21: owned at frame start keeps pointer
// R22: pause with pause enable suspends transmission
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "etdm_consts.svh"
module etdm_tx_desc (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic        mem_err,
  input  wire logic [31:0] mem_rdata,
  output logic             mac_valid,
  input  wire logic        mac_ready,
  output logic      [31:0] mac_data,
  output logic      [2:0]  mac_bytes,
  output logic             mac_last,
  output logic             mac_no_crc,
  output logic             mac_bad_fcs,
  input  wire logic        mac_done,
  input  wire logic        mac_collision,
  input  wire logic        mac_retry_limit,
  input  wire logic        mac_underrun,
  input  wire logic        mac_paused,
  output logic             transmit_error_output
);
  etdm_regs_if r ();
  etdm_pkg::etdm_state_t state_reg;
  logic        go_reg, halt_reg, coll_reg, terr_reg, bad_reg;
  logic [9:0]  idx_reg, first_reg;
  logic [31:0] buf_reg, ctrl_reg, st_reg;
  logic [10:0] len_reg;
  logic        last_reg, nocrc_reg, wrap_reg;
  logic [17:0] fb_reg;
  logic [2:0]  err_reg, lerr_reg;
  logic        req_reg, we_reg;
  logic [31:0] addr_reg, wdata_reg, data_reg;
  logic        val_reg, eof_reg, ncrc_reg;
  logic [2:0]  nb_reg;

  etdm_ahb_regs etdm_ahb_regs_inst (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .r         (r)
  );

  ////////////////////////////////////////////////////////////////////
  // decode and arithmetic
  wire        kill     = ~r.tx_en | r.qp_wr_p;
  wire [31:0] cur_desc = etdm_pkg::desc_addr(r.qp_base, idx_reg);
  wire [31:0] wb_addr  = etdm_pkg::desc_addr(r.qp_base, first_reg) +
                         `ETDM_CTRL_OFS;
  wire        is_first = (idx_reg == first_reg);
  wire        owned    = mem_rdata[`ETDM_D_USED];
  wire        rd_done  = req_reg & mem_ack;
  wire        mac_free = ~val_reg | mac_ready;
  wire        hold     = mac_paused & r.pause_en; // see R22
  // wrap bit or 1024th entry returns to ring start
  wire [9:0]  idx_nxt  = (wrap_reg || idx_reg == `ETDM_RING_LAST) ?
                         10'h000 : idx_reg + 10'h001; // see R10
  wire [10:0] take     = (len_reg >= `ETDM_WORD_BYTES) ?
                         `ETDM_WORD_BYTES : len_reg; // see R1
  wire [17:0] pad_goal = `ETDM_MIN_FRAME - `ETDM_CRC_BYTES;
  wire [17:0] pad_left = pad_goal - fb_reg;
  wire [2:0]  pad_take = (pad_left >= 18'(`ETDM_WORD_BYTES)) ?
                         3'(`ETDM_WORD_BYTES) : pad_left[2:0];
  wire        need_pad = ~nocrc_reg & (fb_reg < pad_goal); // see R4
  // retry limit and underrun status; exhaustion bit always zero
  wire [2:0]  err_mac  = {mac_retry_limit, mac_underrun, 1'b0};
  wire        mac_err  = mac_retry_limit | mac_underrun;
  wire        busy     = (state_reg != etdm_pkg::ST_IDLE);

  ////////////////////////////////////////////////////////////////////
  // descriptor walker; one process keeps the handshakes in step
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= etdm_pkg::ST_IDLE;
      go_reg    <= 1'b0;
      halt_reg  <= 1'b0;
      coll_reg  <= 1'b0;
      terr_reg  <= 1'b0;
      bad_reg   <= 1'b0;
      idx_reg   <= 10'h000;
      first_reg <= 10'h000;
      buf_reg   <= `ETDM_RST_WORD;
      ctrl_reg  <= `ETDM_RST_WORD;
      len_reg   <= 11'h000;
      last_reg  <= 1'b0;
      nocrc_reg <= 1'b0;
      wrap_reg  <= 1'b0;
      fb_reg    <= 18'h00000;
      err_reg   <= 3'h0;
      lerr_reg  <= 3'h0;
      req_reg   <= 1'b0;
      we_reg    <= 1'b0;
      addr_reg  <= `ETDM_RST_WORD;
      wdata_reg <= `ETDM_RST_WORD;
      data_reg  <= `ETDM_RST_WORD;
      val_reg   <= 1'b0;
      eof_reg   <= 1'b0;
      ncrc_reg  <= 1'b0;
      nb_reg    <= 3'h0;
    end else if (kill) begin
      // an outstanding memory access is abandoned here
      state_reg <= etdm_pkg::ST_IDLE;
      go_reg    <= 1'b0; // see R16
      halt_reg  <= 1'b0;
      coll_reg  <= 1'b0;
      idx_reg   <= 10'h000; // see R12 see R13
      req_reg   <= 1'b0;
      val_reg   <= 1'b0;
      bad_reg   <= 1'b0;
    end else begin
      bad_reg <= 1'b0;
      if (val_reg && mac_ready) val_reg <= 1'b0;
      // go is set below the case, so a start beats a same-cycle clear
      if (r.start_p) begin
        halt_reg <= 1'b0;
        terr_reg <= 1'b0;
      end
      if (r.halt_p) halt_reg <= 1'b1; // see R17
      if (mac_collision && busy) coll_reg <= 1'b1;
      case (state_reg)
        etdm_pkg::ST_IDLE: begin
          coll_reg <= 1'b0;
          if (halt_reg) begin
            go_reg   <= 1'b0; // see R16
            halt_reg <= 1'b0;
          end else if (go_reg && !hold) begin
            first_reg <= idx_reg;
            fb_reg    <= 18'h00000;
            err_reg   <= 3'h0;
            state_reg <= etdm_pkg::ST_ADDR;
          end
        end
        etdm_pkg::ST_ADDR, etdm_pkg::ST_CTRL: begin
          if (!req_reg) begin
            req_reg  <= 1'b1;
            we_reg   <= 1'b0;
            addr_reg <= (state_reg == etdm_pkg::ST_ADDR) ?
                        cur_desc : cur_desc + `ETDM_CTRL_OFS; // see R3
          end else if (rd_done) begin
            req_reg <= 1'b0;
            if (mem_err) begin
              err_reg   <= 3'b010; // see R9
              terr_reg  <= 1'b1;
              bad_reg   <= ~is_first;
              state_reg <= etdm_pkg::ST_WB;
            end else if (state_reg == etdm_pkg::ST_ADDR) begin
              buf_reg   <= mem_rdata;
              state_reg <= etdm_pkg::ST_CTRL;
            end else if (owned && is_first) begin
              go_reg    <= 1'b0; // see R6 see R21
              state_reg <= etdm_pkg::ST_IDLE;
            end else if (owned) begin
              err_reg   <= 3'b011; // see R19
              terr_reg  <= 1'b1;
              bad_reg   <= 1'b1;
              state_reg <= etdm_pkg::ST_WB;
            end else begin
              if (is_first) ctrl_reg <= mem_rdata;
              len_reg   <= mem_rdata[`ETDM_D_LEN_MSB:0]; // see R5
              last_reg  <= mem_rdata[`ETDM_D_LAST];
              nocrc_reg <= mem_rdata[`ETDM_D_NOCRC];
              wrap_reg  <= mem_rdata[`ETDM_D_WRAP];
              state_reg <= etdm_pkg::ST_DATA;
            end
          end
        end
        etdm_pkg::ST_DATA, etdm_pkg::ST_PAD, etdm_pkg::ST_WAIT: begin
          if (mac_err && state_reg == etdm_pkg::ST_WAIT) begin
            err_reg   <= err_mac; // see R8
            terr_reg  <= 1'b1;
            state_reg <= etdm_pkg::ST_WB;
          end else if (coll_reg && !req_reg) begin
            idx_reg   <= first_reg; // see R18
            val_reg   <= 1'b0;
            state_reg <= etdm_pkg::ST_IDLE;
          end else if (state_reg == etdm_pkg::ST_WAIT) begin
            if (mac_done) state_reg <= etdm_pkg::ST_WB;
          end else if (state_reg == etdm_pkg::ST_PAD) begin
            if (mac_free) begin
              val_reg  <= 1'b1;
              data_reg <= `ETDM_RST_WORD;
              eof_reg  <= (pad_left == 18'h00000);
              ncrc_reg <= 1'b0;
              nb_reg   <= (pad_left == 18'h00000) ? 3'h0 : pad_take;
              fb_reg   <= fb_reg + 18'(pad_take);
              if (pad_left == 18'h00000) state_reg <= etdm_pkg::ST_WAIT;
            end
          end else if (len_reg == 11'h000 && !req_reg) begin
            // step only on the cycle that leaves this buffer
            if (!last_reg || need_pad || mac_free) idx_reg <= idx_nxt;
            if (!last_reg) begin
              state_reg <= etdm_pkg::ST_ADDR;
            end else if (need_pad) begin
              state_reg <= etdm_pkg::ST_PAD;
            end else if (mac_free) begin
              val_reg   <= 1'b1; // closing beat carries no bytes
              eof_reg   <= 1'b1;
              ncrc_reg  <= nocrc_reg;
              nb_reg    <= 3'h0;
              state_reg <= etdm_pkg::ST_WAIT;
            end
          end else if (!req_reg && mac_free) begin
            req_reg  <= 1'b1;
            we_reg   <= 1'b0;
            addr_reg <= buf_reg;
          end else if (rd_done && mem_err) begin
            req_reg   <= 1'b0;
            err_reg   <= 3'b010; // see R9
            terr_reg  <= 1'b1;
            bad_reg   <= 1'b1;
            val_reg   <= 1'b0;
            state_reg <= etdm_pkg::ST_WB;
          end else if (rd_done) begin
            req_reg  <= 1'b0;
            val_reg  <= 1'b1;
            data_reg <= mem_rdata;
            eof_reg  <= 1'b0;
            ncrc_reg <= 1'b0;
            nb_reg   <= take[2:0];
            len_reg  <= len_reg - take;
            fb_reg   <= fb_reg + 18'(take);
            buf_reg  <= buf_reg + 32'(`ETDM_WORD_BYTES);
          end
        end
        etdm_pkg::ST_WB: begin
          if (!req_reg) begin
            req_reg   <= 1'b1;
            we_reg    <= 1'b1;
            addr_reg  <= wb_addr;
            wdata_reg <= ctrl_reg | (32'(err_reg) << `ETDM_D_EXH) |
                         (32'(err_reg == 3'h0) << `ETDM_D_USED); // see R8
          end else if (mem_ack) begin
            req_reg   <= 1'b0;
            we_reg    <= 1'b0;
            lerr_reg  <= err_reg;
            state_reg <= etdm_pkg::ST_IDLE;
            if (err_reg != 3'h0) begin
              idx_reg <= 10'h000; // see R20
              go_reg  <= 1'b0; // see R16
            end
          end
        end
        default: state_reg <= etdm_pkg::ST_IDLE;
      endcase
      if (r.start_p) go_reg <= 1'b1; // see R14
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign r.go       = go_reg;
  assign r.err_bits = lerr_reg;
  assign r.cur_ptr  = cur_desc;
  assign mem_req    = req_reg;
  assign mem_we     = we_reg;
  assign mem_addr   = addr_reg;
  assign mem_wdata  = wdata_reg;
  assign mac_valid  = val_reg;
  assign mac_data   = data_reg;
  assign mac_bytes  = nb_reg;
  assign mac_last   = eof_reg;
  assign mac_no_crc = ncrc_reg;
  assign mac_bad_fcs = bad_reg;
  assign transmit_error_output = terr_reg;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  qp_clears_go_a: assert property (r.qp_wr_p |=> !go_reg && idx_reg == 10'h000) // see R12
    else $error("pointer write left go or index set");
  dis_rewinds_a: assert property (!r.tx_en |=> idx_reg == 10'h000) // see R13
    else $error("disable did not rewind ring");
  start_sets_a: assert property (r.start_p && !kill |=> go_reg) // see R14
    else $error("start did not set go");
  owned_keeps_a: assert property (state_reg == etdm_pkg::ST_CTRL && rd_done
      && !mem_err && owned && is_first && !kill && !r.start_p
      |=> !go_reg && $stable(idx_reg)) // see R21
    else $error("owned first descriptor moved pointer");
  mid_owned_a: assert property (state_reg == etdm_pkg::ST_CTRL && rd_done
      && !mem_err && owned && !is_first && !kill
      |=> terr_reg && mac_bad_fcs ##1 !mac_bad_fcs) // see R19
    else $error("mid frame owned not flagged");
  wb_used_a: assert property (req_reg && we_reg && err_reg == 3'h0
      |-> mem_wdata[`ETDM_D_USED] && mem_addr == wb_addr) // see R6
    else $error("status write lacks used bit");
  err_rewind_a: assert property (state_reg == etdm_pkg::ST_WB && mem_ack
      && req_reg && err_reg != 3'h0 && !kill && !r.start_p
      |=> idx_reg == 10'h000 && !go_reg) // see R20
    else $error("error did not rewind ring");
  pad_min_a: assert property (val_reg && eof_reg && !ncrc_reg
      |-> fb_reg >= pad_goal) // see R4
    else $error("crc frame shorter than minimum");
  halt_defer_a: assert property (r.halt_p && state_reg == etdm_pkg::ST_WAIT
      && go_reg && !kill && !mac_err |=> go_reg) // see R17
    else $error("halt cut a running frame");
  pause_hold_a: assert property (state_reg == etdm_pkg::ST_IDLE && hold
      && !kill |=> state_reg != etdm_pkg::ST_ADDR) // see R22
    else $error("frame started during pause");

  frame_done_c: cover property (state_reg == etdm_pkg::ST_WB && mem_ack
                                && err_reg == 3'h0);
  collision_c: cover property (coll_reg && state_reg == etdm_pkg::ST_WAIT);
  padding_c: cover property (state_reg == etdm_pkg::ST_PAD && val_reg);
  wrap_c: cover property (state_reg == etdm_pkg::ST_DATA && wrap_reg
                          && len_reg == 11'h000);
endmodule // etdm_tx_desc
`default_nettype wire

// File: etdm_tx_desc_tb_top.sv
// bench of the descriptor engine: ahb tasks, stalling mac sink, memory
// assumes etdm_mem_model and the design files are compiled first
`timescale 1ns/10ps
`default_nettype none
module etdm_tx_desc_tb_top;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [3:0]  lat = 4'h0;
  logic        mac_ready = 1'b0;
  logic        mac_done = 1'b0;
  logic        mac_retry_limit = 1'b0;
  logic        mac_collision = 1'b0;
  logic        mac_underrun = 1'b0;
  logic        mac_paused = 1'b0;
  logic [31:0] hrdata, mem_addr, mem_wdata, mem_rdata, mac_data;
  logic        hreadyout, hresp, mem_req, mem_we, mem_ack, mem_err;
  logic        mac_valid, mac_last, mac_no_crc, mac_bad_fcs;
  logic        transmit_error_output;
  logic [2:0]  mac_bytes;
  logic [31:0] n_bytes = 32'h0, n_last = 32'h0, n_bad = 32'h0;
  logic        last_nocrc = 1'b0;
  int          n_mismatch = 0;
  int          n_tests = 0;
  //////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  etdm_tx_desc etdm_tx_desc_inst (.clk, .sys_rst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_err,
    .mem_rdata, .mac_valid, .mac_ready, .mac_data, .mac_bytes, .mac_last,
    .mac_no_crc, .mac_bad_fcs, .mac_done, .mac_collision, .mac_retry_limit,
    .mac_underrun, .mac_paused, .transmit_error_output);
  etdm_mem_model etdm_mem_model_inst (.clk, .sys_rst, .lat, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_err, .mem_rdata);
  //////////////////////////////////////////////////////////////////////
  // sink stalls every other cycle to exercise the hold of each beat
  always @(posedge clk) begin
    mac_ready <= ~mac_ready;
    if (mac_bad_fcs) begin
      n_bad <= n_bad + 32'h1;
    end
    if (mac_valid && mac_ready && mac_last) begin
      n_last     <= n_last + 32'h1;
      last_nocrc <= mac_no_crc;
    end else if (mac_valid && mac_ready) begin
      n_bytes <= n_bytes + {29'h0, mac_bytes};
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    ahb(1'b0, a, 32'h0000_0000, q);
  endtask
  task automatic wait_frame(input logic [31:0] l0);
    for (int i = 0; i < 3000 && n_last == l0; i++) @(posedge clk);
    chk(n_last, l0 + 32'h1);
  endtask
  task automatic end_frame(input logic retry);
    @(posedge clk);
    mac_done        <= !retry;
    mac_retry_limit <= retry;
    @(posedge clk);
    mac_done        <= 1'b0;
    mac_retry_limit <= 1'b0;
  endtask
  task automatic wait_wb(input logic [31:0] a, input logic [31:0] exp);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 3000 && !seen; i++) begin
      @(posedge clk);
      seen = mem_req && mem_we && mem_ack && mem_addr == a;
    end
    chk(etdm_mem_model_inst.mem[a[9:2]], exp);
  endtask
  task automatic idle_at(input logic [31:0] ptr);
    logic [31:0] q;
    q = 32'h0000_0008;
    for (int i = 0; i < 100 && q[3] !== 1'b0; i++) rd(32'h08, q);
    chk(q & 32'h0000_0008, 32'h0000_0000);
    rd(32'h0C, q);
    chk(q, ptr);
  endtask
  task automatic close_out;
    $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  initial begin
    logic [31:0] q, b0, l0, f0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(32'h08, q);
    chk(q, 32'h0000_0000);
    etdm_mem_model_inst.mem[64] = 32'h0000_0200;
    etdm_mem_model_inst.mem[65] = 32'h0000_8005;
    etdm_mem_model_inst.mem[66] = 32'h0000_0204;
    etdm_mem_model_inst.mem[67] = 32'h8000_0000;
    b0 = n_bytes;
    l0 = n_last;
    wr(32'h0C, 32'h0000_0100);
    wr(32'h00, 32'h0000_0208);
    rd(32'h08, q);
    chk(q & 32'h0000_0008, 32'h0000_0008);
    wr(32'h00, 32'h0000_0208);
    wait_frame(l0);
    chk(n_bytes - b0, 32'h0000_003C);
    end_frame(1'b0);
    wait_wb(32'h104, 32'h8000_8005);
    idle_at(32'h0000_0108);
    // slow memory; zero length buffer without crc, wrap set
    etdm_mem_model_inst.mem[67] = 32'h4001_8000;
    lat <= 4'h3;
    b0 = n_bytes;
    l0 = n_last;
    wr(32'h00, 32'h0000_0208);
    wait_frame(l0);
    chk(n_bytes - b0, 32'h0000_0000);
    chk({31'h0, last_nocrc}, 32'h0000_0001);
    end_frame(1'b0);
    wait_wb(32'h10C, 32'hC001_8000);
    idle_at(32'h0000_0100);
    // owned descriptor in mid frame
    etdm_mem_model_inst.mem[65] = 32'h0000_0004;
    etdm_mem_model_inst.mem[67] = 32'h8000_8000;
    f0 = n_bad;
    wr(32'h0C, 32'h0000_0100);
    wr(32'h00, 32'h0000_0208);
    wait_wb(32'h104, 32'h1800_0004);
    idle_at(32'h0000_0100);
    chk(n_bad - f0, 32'h0000_0001);
    chk({31'h0, transmit_error_output}, 32'h0000_0001);
    // retry limit reported by the mac core
    etdm_mem_model_inst.mem[65] = 32'h0000_8005;
    l0 = n_last;
    wr(32'h0C, 32'h0000_0100);
    wr(32'h00, 32'h0000_0208);
    wait_frame(l0);
    end_frame(1'b1);
    wait_wb(32'h104, 32'h2000_8005);
    idle_at(32'h0000_0100);
    rd(32'h08, q);
    chk(q & 32'h3800_0000, 32'h2000_0000);
    // pause holds a started ring; halt waits for the frame end
    etdm_mem_model_inst.mem[65] = 32'h0000_8005;
    l0 = n_last;
    mac_paused <= 1'b1;
    wr(32'h04, 32'h0000_2000);
    wr(32'h00, 32'h0000_0208);
    repeat (20) @(posedge clk);
    chk({31'h0, mem_req}, 32'h0000_0000);
    mac_paused <= 1'b0;
    wr(32'h00, 32'h0000_0408);
    wait_frame(l0);
    end_frame(1'b0);
    wait_wb(32'h104, 32'h8000_8005);
    idle_at(32'h0000_0108);
    wr(32'h00, 32'h0000_0000);
    idle_at(32'h0000_0100);
    // collision after the closing beat: frame sent again
    etdm_mem_model_inst.mem[65] = 32'h0000_8005;
    b0 = n_bytes;
    l0 = n_last;
    wr(32'h00, 32'h0000_0208);
    wait_frame(l0);
    mac_collision <= 1'b1;
    @(posedge clk);
    mac_collision <= 1'b0;
    wait_frame(l0 + 32'h1);
    chk(n_bytes - b0, 32'h0000_0078);
    end_frame(1'b0);
    wait_wb(32'h104, 32'h8000_8005);
    close_out();
  end
endmodule // etdm_tx_desc_tb_top
`default_nettype wire
